// File: shared/pmc_map.svh
// Register offsets, reset values and field positions of the port mode block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (8-bit register space)
// ----------------------------------------------------------------------
`define PMC_OFS_PORT0_LATCH 8'h80
`define PMC_OFS_PORT1_LATCH 8'h90
`define PMC_OFS_PORT2_LATCH 8'ha0
`define PMC_OFS_PORT3_LATCH 8'hb0
`define PMC_OFS_PORT4_MODE_LOW 8'hbe
`define PMC_OFS_PORT4_MODE_HIGH 8'hbf
`define PMC_OFS_PORT4_LATCH 8'hc0
`define PMC_OFS_PORT3_MODE_LOW 8'hc6
`define PMC_OFS_PORT3_MODE_HIGH 8'hc7
`define PMC_OFS_PORT2_MODE_LOW 8'hce
`define PMC_OFS_PORT2_MODE_HIGH 8'hcf
`define PMC_OFS_PORT1_MODE_LOW 8'hd6
`define PMC_OFS_PORT1_MODE_HIGH 8'hd7
`define PMC_OFS_PORT0_MODE_LOW 8'he6
`define PMC_OFS_PORT0_MODE_HIGH 8'he7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMC_RST_LATCH 8'hff
// Tristate option programmed: input-only is high 1, low 0
`define PMC_RST_TRI_HIGH 8'hff
`define PMC_RST_TRI_LOW 8'h00
// Option clear, ports 1..4: quasi-bidirectional is 00
`define PMC_RST_QUASI_HIGH 8'h00
`define PMC_RST_QUASI_LOW 8'h00
// Option clear, port 0: open-drain is 11
`define PMC_RST_OPEN_HIGH 8'hff
`define PMC_RST_OPEN_LOW 8'hff
// Value returned for an unmapped read
`define PMC_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMC_UPPER_LSB 4
`define PMC_PORT_W 8
`define PMC_PORT_N 5

`endif

// File: shared/pmc_pkg.sv
// Types shared by the port mode block
package pmc_pkg;

    // Pin operating mode; high register bit is the upper bit of the pair
    typedef enum logic [1:0] {
        PMC_QUASI = 2'h0,
        PMC_PUSH_PULL = 2'h1,
        PMC_INPUT_ONLY = 2'h2,
        PMC_OPEN_DRAIN = 2'h3
    } pmc_mode_t;

endpackage

// File: hdl/pmc_pin_cell.sv
// One pin's driver decode from its two mode bits and its latch bit
`timescale 1ns/1ps
module pmc_pin_cell (
    // Configuration
    input wire logic mode_high_i,
    input wire logic mode_low_i,
    input wire logic latch_i,
    input wire logic pull_in_push_i,
    // Pad controls
    output logic out_o,
    output logic oe_o,
    output logic pullup_o
);
    pmc_pkg::pmc_mode_t mode;

    // Pair of mode bits, high register is the upper bit
    assign mode = pmc_pkg::pmc_mode_t'({mode_high_i, mode_low_i});

    // Driver decode; quasi drives low only, the pull-up gives the high
    always_comb begin
        out_o = 1'b0;
        oe_o = 1'b0;
        pullup_o = 1'b0;
        case (mode)
            pmc_pkg::PMC_QUASI: begin
                oe_o = ~latch_i;
                pullup_o = 1'b1;
            end
            pmc_pkg::PMC_PUSH_PULL: begin
                out_o = latch_i;
                oe_o = 1'b1;
                pullup_o = pull_in_push_i;
            end
            pmc_pkg::PMC_INPUT_ONLY: begin
                oe_o = 1'b0;
            end
            pmc_pkg::PMC_OPEN_DRAIN: begin
                oe_o = ~latch_i;
            end
            default: begin
                oe_o = 1'b0;
            end
        endcase
    end
endmodule

// File: hdl/pmc_port_config.sv
// Mode and latch registers and pad control for five 8-bit ports
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "pmc_map.svh"

// Operation
// - First four ports each selectable among four pin modes by software
// - Pin mode comes from same bit of the port's two mode registers
// - Tristate option set: all configurable pins input-only after reset
// - Option clear: second to fourth ports reset to quasi-bidirectional
// - Option clear: first port resets open-drain without pull-ups
// - Fifth port pins quasi-bidirectional regardless of registers, except upper pins while their dedicated use needs them
// - First port pull-ups on in quasi-bidirectional and push-pull modes
// - Fifth port upper pins replace latch, store-enable and crystal pins
// - Upper pins free for I/O only when their dedicated use is off
module pmc_port_config (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // User option and dedicated-function needs
    input wire logic tristate_opt_i,
    input wire logic [3:0] dedicated_need_i,
    input wire logic [3:0] dedicated_out_i,
    input wire logic [3:0] dedicated_oe_i,
    // Pads, port n occupies bits 8n+7..8n
    input wire logic [39:0] pin_in_i,
    output logic [39:0] pin_out_o,
    output logic [39:0] pin_oe_o,
    output logic [39:0] pin_pullup_o,
    // Upper fifth-port pins released for general I/O
    output logic [3:0] upper_gpio_o
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] latch [0:4];
    logic [7:0] mode_low [0:4];
    logic [7:0] mode_high [0:4];
    logic opt_meta;
    logic opt_sync;
    logic [39:0] pin_meta;
    logic [39:0] pin_sync;
    logic [39:0] cell_out;
    logic [39:0] cell_oe;
    logic [39:0] cell_pullup;
    logic [39:0] next_out;
    logic [39:0] next_oe;
    logic [39:0] next_pullup;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Option and pads come from outside the clock domain; not reset so
    // the option is already settled when reset picks its defaults
    always_ff @(posedge clock_i) begin
        opt_meta <= tristate_opt_i;
        opt_sync <= opt_meta;
    end

    // Pad levels for readback
    always_ff @(posedge clock_i) begin
        pin_meta <= pin_in_i;
        pin_sync <= pin_meta;
    end

    // ------------------------------------------------------------------
    // Pin latches
    // ------------------------------------------------------------------
    // Latches come up high so quasi pins float up after reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `PMC_PORT_N; i++) begin
                latch[i] <= `PMC_RST_LATCH;
            end
        end else if (wr_i) begin
            case (addr_i)
                `PMC_OFS_PORT0_LATCH: latch[0] <= wdata_i;
                `PMC_OFS_PORT1_LATCH: latch[1] <= wdata_i;
                `PMC_OFS_PORT2_LATCH: latch[2] <= wdata_i;
                `PMC_OFS_PORT3_LATCH: latch[3] <= wdata_i;
                `PMC_OFS_PORT4_LATCH: latch[4] <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------------
    // Reset default depends on the tristate option
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            if (opt_sync) begin
                for (int i = 0; i < `PMC_PORT_N; i++) begin
                    mode_low[i] <= `PMC_RST_TRI_LOW;
                    mode_high[i] <= `PMC_RST_TRI_HIGH;
                end
            end else begin
                mode_low[0] <= `PMC_RST_OPEN_LOW;
                mode_high[0] <= `PMC_RST_OPEN_HIGH;
                for (int i = 1; i < `PMC_PORT_N; i++) begin
                    mode_low[i] <= `PMC_RST_QUASI_LOW;
                    mode_high[i] <= `PMC_RST_QUASI_HIGH;
                end
            end
        end else if (wr_i) begin
            // Software may change any pin mode of the first four ports at any time
            case (addr_i)
                `PMC_OFS_PORT0_MODE_LOW: mode_low[0] <= wdata_i;
                `PMC_OFS_PORT0_MODE_HIGH: mode_high[0] <= wdata_i;
                `PMC_OFS_PORT1_MODE_LOW: mode_low[1] <= wdata_i;
                `PMC_OFS_PORT1_MODE_HIGH: mode_high[1] <= wdata_i;
                `PMC_OFS_PORT2_MODE_LOW: mode_low[2] <= wdata_i;
                `PMC_OFS_PORT2_MODE_HIGH: mode_high[2] <= wdata_i;
                `PMC_OFS_PORT3_MODE_LOW: mode_low[3] <= wdata_i;
                `PMC_OFS_PORT3_MODE_HIGH: mode_high[3] <= wdata_i;
                `PMC_OFS_PORT4_MODE_LOW: mode_low[4] <= wdata_i;
                `PMC_OFS_PORT4_MODE_HIGH: mode_high[4] <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-pin driver decode
    // ------------------------------------------------------------------
    // Fifth port is fed a quasi pair whatever its registers hold; its
    // registers still store for software compatibility
    for (genvar p = 0; p < `PMC_PORT_N; p++) begin : g_port
        for (genvar b = 0; b < `PMC_PORT_W; b++) begin : g_bit
            logic m_high;
            logic m_low;
            // Same bit position of both registers forms the pair
            assign m_high = (p == 4) ? 1'b0 : mode_high[p][b];
            assign m_low = (p == 4) ? 1'b0 : mode_low[p][b];
            pmc_pin_cell u_cell (
                .mode_high_i(m_high),
                .mode_low_i(m_low),
                .latch_i(latch[p][b]),
                .pull_in_push_i((p == 0) ? 1'b1 : 1'b0),
                .out_o(cell_out[p*8+b]),
                .oe_o(cell_oe[p*8+b]),
                .pullup_o(cell_pullup[p*8+b])
            );
        end
    end

    // ------------------------------------------------------------------
    // Upper fifth-port pins
    // ------------------------------------------------------------------
    // A pin still needed by the clock or external memory stays with its
    // dedicated function; general I/O gets it only when that is off
    assign upper_gpio_o = ~dedicated_need_i;

    always_comb begin
        next_out = cell_out;
        next_oe = cell_oe;
        next_pullup = cell_pullup;
        for (int u = 0; u < 4; u++) begin
            if (dedicated_need_i[u]) begin
                next_out[32+`PMC_UPPER_LSB+u] = dedicated_out_i[u];
                next_oe[32+`PMC_UPPER_LSB+u] = dedicated_oe_i[u];
                next_pullup[32+`PMC_UPPER_LSB+u] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pad outputs
    // ------------------------------------------------------------------
    // Registered so pads see no decode glitches; all pads float in reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_out_o <= 40'h0;
            pin_oe_o <= 40'h0;
            pin_pullup_o <= 40'h0;
        end else begin
            pin_out_o <= next_out;
            pin_oe_o <= next_oe;
            pin_pullup_o <= next_pullup;
        end
    end

    // ------------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------------
    // Latch addresses read the pad level, as port reads do on this core;
    // a driven-low quasi pin therefore reads back low
    always_comb begin
        case (addr_i)
            `PMC_OFS_PORT0_LATCH: next_rdata = pin_sync[7:0];
            `PMC_OFS_PORT1_LATCH: next_rdata = pin_sync[15:8];
            `PMC_OFS_PORT2_LATCH: next_rdata = pin_sync[23:16];
            `PMC_OFS_PORT3_LATCH: next_rdata = pin_sync[31:24];
            `PMC_OFS_PORT4_LATCH: next_rdata = pin_sync[39:32];
            `PMC_OFS_PORT0_MODE_LOW: next_rdata = mode_low[0];
            `PMC_OFS_PORT0_MODE_HIGH: next_rdata = mode_high[0];
            `PMC_OFS_PORT1_MODE_LOW: next_rdata = mode_low[1];
            `PMC_OFS_PORT1_MODE_HIGH: next_rdata = mode_high[1];
            `PMC_OFS_PORT2_MODE_LOW: next_rdata = mode_low[2];
            `PMC_OFS_PORT2_MODE_HIGH: next_rdata = mode_high[2];
            `PMC_OFS_PORT3_MODE_LOW: next_rdata = mode_low[3];
            `PMC_OFS_PORT3_MODE_HIGH: next_rdata = mode_high[3];
            `PMC_OFS_PORT4_MODE_LOW: next_rdata = mode_low[4];
            `PMC_OFS_PORT4_MODE_HIGH: next_rdata = mode_high[4];
            default: next_rdata = `PMC_RD_UNMAPPED;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

// File: verif/pmc_board_model.sv
// Board circuitry model that resolves each pad from the block's drive
`timescale 1ns/1ps
module pmc_board_model (
    // Clock for the floating-line pattern
    input wire logic clock_i,
    // Pad controls from the block
    input wire logic [39:0] pin_out_i,
    input wire logic [39:0] pin_oe_i,
    input wire logic [39:0] pin_pullup_i,
    // Resolved pad levels
    output logic [39:0] pin_level_o
);
    logic flip = 1'b0;
    // A pad with no drive and no pull-up floats; a changing level keeps
    // the simulator from hiding it behind a steady guess
    always @(posedge clock_i) begin
        flip <= !flip;
    end
    // Driven pads follow the block, others the pull-up or the float
    assign pin_level_o = (pin_oe_i & pin_out_i)
        | (~pin_oe_i & (pin_pullup_i | {40{flip}}));
endmodule

// File: verif/pmc_port_config_asserts.sv
// Checker of pad states and read-port timing for the port mode block
`timescale 1ns/1ps
module pmc_port_config_asserts (
    // Observed ports
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic rd_i,
    input wire logic tristate_opt_i,
    input wire logic [3:0] dedicated_need_i,
    input wire logic [3:0] dedicated_out_i,
    input wire logic [3:0] dedicated_oe_i,
    input wire logic [7:0] rdata_o,
    input wire logic [39:0] pin_out_o,
    input wire logic [39:0] pin_oe_o,
    input wire logic [39:0] pin_pullup_o,
    input wire logic [3:0] upper_gpio_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic up_q;
    // Pads carry decoded values only from the first edge after release
    always_ff @(posedge clock_i) up_q <= rst_n_i;
    a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_upper_free_flag: assert property (upper_gpio_o == ~dedicated_need_i)
        else $error("upper release flag wrong");
    a_upper_dedicated_drive: assert property (up_q |->
        (((pin_oe_o[39:36] ^ $past(dedicated_oe_i))
        | pin_pullup_o[39:36]) & $past(dedicated_need_i)) == 4'h0
        && ((pin_out_o[39:36] ^ $past(dedicated_out_i))
        & $past(dedicated_need_i) & $past(dedicated_oe_i)) == 4'h0)
        else $error("dedicated pin drive wrong");
    a_upper_quasi_pull: assert property (up_q |->
        (pin_pullup_o[39:36] | $past(dedicated_need_i)) == 4'hf)
        else $error("free upper pin pull-up off");
    a_fifth_always_quasi: assert property (up_q |->
        pin_pullup_o[35:32] == 4'hf && pin_out_o[35:32] == 4'h0)
        else $error("fifth port not quasi");
    a_reset_no_drive: assert property (disable iff (1'b0) !rst_n_i |=>
        pin_oe_o == 40'h0 && pin_pullup_o == 40'h0)
        else $error("pads active in reset");
    a_tristate_start: assert property ($rose(up_q) && tristate_opt_i |->
        pin_oe_o[31:0] == 32'h0 && pin_pullup_o[31:0] == 32'h0)
        else $error("tristate start wrong");
    a_default_start: assert property ($rose(up_q) && !tristate_opt_i |->
        pin_oe_o[31:0] == 32'h0 && pin_pullup_o[31:0] == 32'hffffff00)
        else $error("default start wrong");
    c_tri_start: cover property ($rose(up_q) && tristate_opt_i);
    c_dedicated: cover property (up_q && dedicated_need_i != 4'h0);
    c_read: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule
bind pmc_port_config pmc_port_config_asserts chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .rd_i(rd_i),
    .tristate_opt_i(tristate_opt_i), .dedicated_need_i(dedicated_need_i),
    .dedicated_out_i(dedicated_out_i), .dedicated_oe_i(dedicated_oe_i),
    .rdata_o(rdata_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .upper_gpio_o(upper_gpio_o)
);

// File: verif/tb_pmc_port_config.sv
// Self-checking bench for the port mode block
`timescale 1ns/1ps
module tb_pmc_port_config;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic tri_opt = 1'b0;
    logic [3:0] need = 4'h0;
    logic [3:0] ded_out = 4'h0;
    logic [3:0] ded_oe = 4'h0;
    logic [7:0] rdata_o;
    logic [39:0] pin_in, pin_out, pin_oe, pin_pu;
    logic [3:0] upper_gpio;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    // Mode-low offsets; each mode-high sits one above
    localparam logic [7:0] ML [5] = '{8'he6, 8'hd6, 8'hce, 8'hc6, 8'hbe};
    localparam logic [7:0] LA [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
    // 100 MHz system clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    pmc_port_config dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .tristate_opt_i(tri_opt), .dedicated_need_i(need),
        .dedicated_out_i(ded_out), .dedicated_oe_i(ded_oe),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .pin_pullup_o(pin_pu), .upper_gpio_o(upper_gpio)
    );
    pmc_board_model brd_u (
        .clock_i(clock_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pin_pullup_i(pin_pu), .pin_level_o(pin_in)
    );
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Cut a hang short; the tests need about a hundred cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 check({32'h0, rdata_o}, {32'h0, exp});
    endtask
    // Pads follow a register or input change by exactly one edge
    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask
    task automatic t_reset(input logic opt);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        tri_opt <= opt;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 check({8'h0, pin_oe[31:0]}, 40'h0);
        check(pin_pu, opt ? 40'hff00000000 : 40'hffffffff00);
        for (int p = 0; p < 5; p++) begin
            rd_chk(ML[p], (!opt && p == 0) ? 8'hff : 8'h00);
            rd_chk(ML[p] + 8'h01, (opt || p == 0) ? 8'hff : 8'h00);
        end
        if (!opt) rd_chk(LA[1], 8'hff);
        $display("reset test done, option %0d", opt);
    endtask
    task automatic t_modes();
        logic [39:0] eo, ex, ep;
        eo = 40'h0;
        ex = 40'h0;
        ep = 40'hff00000000;
        for (int p = 0; p < 4; p++) begin
            wr(ML[p], 8'haa);
            wr(ML[p] + 8'h01, 8'hcc);
            wr(LA[p], 8'hf0);
            for (int b = 0; b < 8; b++) begin
                eo[8*p+b] = b[1:0] == 2'h1 || (b[1] == b[0] && !b[2]);
                ex[8*p+b] = b[1:0] == 2'h1 && b[2];
                ep[8*p+b] = b[1:0] == 2'h0 || (b[1:0] == 2'h1 && p == 0);
            end
        end
        settle();
        check(pin_oe, eo);
        check(pin_out & pin_oe, ex);
        check(pin_pu, ep);
        rd_chk(8'hc7, 8'hcc);
        $display("mode decode test done");
    endtask
    task automatic t_fifth();
        wr(8'hbe, 8'hff);
        wr(8'hbf, 8'hff);
        wr(8'hc0, 8'h00);
        need <= 4'h5;
        ded_oe <= 4'h3;
        ded_out <= 4'h1;
        settle();
        check({32'h0, pin_oe[39:32]}, 40'hbf);
        check({32'h0, pin_out[39:32] & pin_oe[39:32]}, 40'h10);
        check({32'h0, pin_pu[39:32]}, 40'haf);
        check({36'h0, upper_gpio}, 40'ha);
        rd_chk(8'hbf, 8'hff);
        wr(8'h81, 8'h00);
        rd_chk(8'h81, 8'h00);
        // Release the dedicated needs on an edge, like every other input
        @(posedge clock_i);
        need <= 4'h0;
        $display("fifth port test done");
    endtask
    initial begin
        t_reset(1'b0);
        t_modes();
        t_fifth();
        t_reset(1'b1);
        finish_test();
    end
endmodule
